/* File: src/ldc_pkg.sv */
// Purpose: Shared constants and types of the LCD drive control block
// Assumes: 4-bit CPU data bus, 16-bit memory-mapped addresses
// Notes: Display memory is three pages of nibbles
package ldc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] LCD_DRIVE_CONFIG_ADDR = 16'hFF60;
  localparam logic [15:0] LCD_DISPLAY_OVERRIDE_ADDR = 16'hFF61;
  localparam logic [15:0] LCD_CONTRAST_LEVEL_ADDR = 16'hFF62;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_SUPPLY_BIT = 0;
  localparam int CFG_DUMMY_BIT = 1;
  localparam int CFG_DUTY_LOW_BIT = 2;
  localparam int CFG_DUTY_HIGH_BIT = 3;
  localparam int OVR_PAGE_BIT = 0;
  localparam int OVR_LIT_BIT = 1;
  localparam int OVR_DARK_BIT = 2;
  localparam int OVR_EXP_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [3:0] CFG_RESET_48X8 = 4'h8;
  localparam logic [3:0] OVR_RESET = 4'h4;
  localparam logic [3:0] CONTRAST_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Display memory layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE0_HIGH = 8'hF0;
  localparam logic [7:0] PAGE1_HIGH = 8'hF1;
  localparam logic [7:0] PAGE2_HIGH = 8'hF2;
  localparam logic [7:0] PAGE_LAST = 8'h5F;
  localparam int PAGE_DEPTH = 96;
  localparam int PAGE2_DEPTH = 48;
  localparam int SEG_COUNT = 48;
  localparam int SEG_COUNT_40 = 40;
  localparam int COM_COUNT = 17;
  localparam logic [4:0] COM_LAST_8 = 5'h07;
  localparam logic [4:0] COM_LAST_16 = 5'h0F;
  localparam logic [4:0] COM_LAST_17 = 5'h10;
  localparam logic [4:0] COM_EXTRA = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } ldc_bus_type;

  typedef enum logic [1:0] {
    DUTY_17,
    DUTY_16,
    DUTY_8
  } ldc_duty_type;

endpackage

/* File: src/ldc_lcd_drive_control.sv */
// Purpose: Control registers, display memory and common scan of the LCD driver
// Assumes: Low-speed clock domain, scan_tick marks one common period
// Notes: Drive voltages and waveforms are produced outside this block
// Functional notes
// RULE1: Supply enable bit turns generator on; cleared forces all drive to ground.
// RULE2: Software waits about 100 ms after enabling supply before display.
// RULE3: Reset clears supply, duty, all-lit, page, expanded bits; sets all-dark.
// RULE4: Duty code 1x gives 1/8, 01 gives 1/16, 00 gives 1/17.
// RULE5: In 48x8 layout duty resets to 1/8 and only 1/8 applies.
// RULE6: All-lit bit drives every segment on, memory untouched.
// RULE7: All-dark bit drives every segment off, memory untouched.
// RULE8: All-lit wins when both override bits are set.
// RULE9: At 1/8 duty page select picks F100 page or F000 page.
// RULE10: At 1/16 or 1/17 duty page select is plain storage.
// RULE11: Four-bit contrast code, readable and writable, sixteen levels.
// RULE12: Software initialises contrast and display memory before display.
// RULE13: 40x17 layout nibble pairs map commons 0-7, 8-15, 16 per segment.
// RULE14: 48x8 layout both pages hold segments 0-47 for commons 0-7.
// RULE15: Software avoids unimplemented display memory addresses.
// RULE16: Expanded-driver bit gates the signals for an external driver.
// RULE17: Memory bit 1 lights its dot, 0 leaves it dark.
`timescale 1ns/1ps
module ldc_lcd_drive_control #(
  parameter bit LAYOUT_48X8 = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // CPU bus
  input wire ldc_pkg::ldc_bus_type bus_in,
  output logic [3:0] rd_data,
  // Scan timing
  input wire logic scan_tick,
  // Panel side
  output logic drive_supply_enable,
  output logic [3:0] contrast_code,
  output logic [ldc_pkg::COM_COUNT-1:0] common_line,
  output logic [ldc_pkg::SEG_COUNT-1:0] segment_line,
  output logic [1:0] duty_active,
  // Expanded driver
  output logic exp_scan_pulse,
  output logic exp_frame_start,
  output logic [4:0] exp_common_index
);
  import ldc_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0] cfg_reg;
  logic [3:0] ovr_reg;
  logic [3:0] contrast_reg;
  logic [3:0] page0_reg [PAGE_DEPTH];
  logic [3:0] page1_reg [PAGE_DEPTH];
  logic [3:0] page2_reg [PAGE2_DEPTH];
  logic [4:0] com_reg;
  logic [3:0] rd_data_reg;
  logic [COM_COUNT-1:0] common_reg;
  logic [SEG_COUNT-1:0] seg_reg;
  logic exp_pulse_reg;
  logic exp_frame_reg;
  logic [4:0] exp_index_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [7:0] addr_high = bus_in.addr[15:8];
  wire [7:0] addr_low = bus_in.addr[7:0];
  wire in_range = addr_low <= PAGE_LAST;
  wire sel_page0 = (addr_high == PAGE0_HIGH) && in_range;
  wire sel_page1 = (addr_high == PAGE1_HIGH) && in_range;
  wire sel_page2 = !LAYOUT_48X8 && (addr_high == PAGE2_HIGH) && in_range
                   && !addr_low[0];
  wire sel_cfg = bus_in.addr == LCD_DRIVE_CONFIG_ADDR;
  wire sel_ovr = bus_in.addr == LCD_DISPLAY_OVERRIDE_ADDR;
  wire sel_contrast = bus_in.addr == LCD_CONTRAST_LEVEL_ADDR;
  wire [6:0] mem_index = addr_low[6:0];
  wire [5:0] page2_index = addr_low[6:1];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic ldc_duty_type duty_of(input logic [3:0] cfg);
    if (LAYOUT_48X8 || cfg[CFG_DUTY_HIGH_BIT]) begin
      return DUTY_8; // RULE4 RULE5
    end
    return cfg[CFG_DUTY_LOW_BIT] ? DUTY_16 : DUTY_17; // RULE4
  endfunction

  wire ldc_duty_type duty = duty_of(cfg_reg);
  wire [1:0] duty_code = duty;
  wire supply_on = cfg_reg[CFG_SUPPLY_BIT];
  wire force_all_lit = ovr_reg[OVR_LIT_BIT];
  wire force_all_dark = ovr_reg[OVR_DARK_BIT];
  wire display_page_select = ovr_reg[OVR_PAGE_BIT];
  wire expanded_driver_enable = ovr_reg[OVR_EXP_BIT];
  wire duty_select_high = cfg_reg[CFG_DUTY_HIGH_BIT];
  wire duty_select_low = cfg_reg[CFG_DUTY_LOW_BIT];

  logic [4:0] com_last;
  always_comb begin
    unique case (duty)
      DUTY_8: com_last = COM_LAST_8;
      DUTY_16: com_last = COM_LAST_16;
      DUTY_17: com_last = COM_LAST_17;
      default: com_last = COM_LAST_8;
    endcase
  end

  wire com_wrap = com_reg >= com_last;
  wire [4:0] com_next = com_wrap ? 5'h00 : com_reg + 5'h01;

  // ----------------------------------------------------------------
  // Dot lookup
  // ----------------------------------------------------------------
  // Returns the memory bit for one common and one segment
  function automatic logic dot_of(input logic [4:0] c, input int s);
    logic [6:0] idx;
    logic [1:0] bit_sel;
    idx = 7'(2 * s) + {6'h00, c[2]};
    bit_sel = c[1:0];
    if (duty == DUTY_8) begin
      if (display_page_select) begin
        return page1_reg[idx][bit_sel]; // RULE9 RULE14
      end
      return page0_reg[idx][bit_sel]; // RULE9 RULE14
    end
    if (c == COM_EXTRA) begin
      return page2_reg[s][0]; // RULE13
    end
    if (c[3]) begin
      return page1_reg[idx][bit_sel]; // RULE13 RULE10
    end
    return page0_reg[idx][bit_sel]; // RULE13
  endfunction

  logic [SEG_COUNT-1:0] seg_next;
  for (genvar s = 0; s < SEG_COUNT; s++) begin : g_seg
    localparam bit USED = LAYOUT_48X8 || (s < SEG_COUNT_40);
    wire dot = USED ? dot_of(com_next, s) : 1'b0; // RULE17
    assign seg_next[s] = !supply_on ? 1'b0 : // RULE1
                         force_all_lit ? USED : // RULE6 RULE8
                         force_all_dark ? 1'b0 : dot; // RULE7
  end

  wire [COM_COUNT-1:0] common_next = supply_on ? (COM_COUNT'(1) << com_next)
                                               : '0; // RULE1

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [3:0] rd_next;
  always_comb begin
    rd_next = 4'h0;
    if (sel_cfg) begin
      rd_next = cfg_reg;
    end else if (sel_ovr) begin
      rd_next = ovr_reg;
    end else if (sel_contrast) begin
      rd_next = contrast_reg; // RULE11
    end else if (sel_page0) begin
      rd_next = page0_reg[mem_index];
    end else if (sel_page1) begin
      rd_next = page1_reg[mem_index];
    end else if (sel_page2) begin
      rd_next = page2_reg[page2_index];
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= LAYOUT_48X8 ? CFG_RESET_48X8 : CFG_RESET; // RULE3 RULE5
      ovr_reg <= OVR_RESET; // RULE3
      contrast_reg <= CONTRAST_RESET;
    end else if (bus_in.wr) begin
      if (sel_cfg) begin
        cfg_reg <= bus_in.wdata; // RULE1 RULE4
      end
      if (sel_ovr) begin
        ovr_reg <= bus_in.wdata; // RULE6 RULE7 RULE10 RULE16
      end
      if (sel_contrast) begin
        contrast_reg <= bus_in.wdata; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Display memory
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        page0_reg[i] <= 4'h0;
        page1_reg[i] <= 4'h0;
      end
      for (int i = 0; i < PAGE2_DEPTH; i++) begin
        page2_reg[i] <= 4'h0;
      end
    end else if (bus_in.wr) begin
      if (sel_page0) begin
        page0_reg[mem_index] <= bus_in.wdata;
      end
      if (sel_page1) begin
        page1_reg[mem_index] <= bus_in.wdata;
      end
      if (sel_page2) begin
        page2_reg[page2_index] <= bus_in.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Common scan and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      com_reg <= COM_LAST_17;
      common_reg <= '0;
      seg_reg <= '0;
    end else if (scan_tick) begin
      com_reg <= com_next;
      common_reg <= common_next;
      seg_reg <= seg_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 4'h0;
      exp_pulse_reg <= 1'b0;
      exp_frame_reg <= 1'b0;
      exp_index_reg <= 5'h00;
    end else begin
      if (bus_in.rd) begin
        rd_data_reg <= rd_next;
      end
      exp_pulse_reg <= expanded_driver_enable && scan_tick; // RULE16
      exp_frame_reg <= expanded_driver_enable && scan_tick && com_wrap; // RULE16
      exp_index_reg <= expanded_driver_enable ? com_reg : 5'h00; // RULE16
    end
  end

  assign rd_data = rd_data_reg;
  assign drive_supply_enable = cfg_reg[CFG_SUPPLY_BIT]; // RULE1
  assign contrast_code = contrast_reg; // RULE11
  assign common_line = common_reg;
  assign segment_line = seg_reg;
  assign duty_active = duty_code;
  assign exp_scan_pulse = exp_pulse_reg;
  assign exp_frame_start = exp_frame_reg;
  assign exp_common_index = exp_index_reg;

  wire unused_bits = duty_select_high ^ duty_select_low ^ cfg_reg[CFG_DUMMY_BIT];

endmodule

/* File: testbench/ldc_properties.sv */
// Purpose: Port assertions of the LCD drive control block
// Assumes: Register state is inferred from CPU bus writes
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module ldc_properties #(
  parameter bit LAYOUT_48X8 = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus and scan
  input wire ldc_pkg::ldc_bus_type bus_in,
  input wire logic [3:0] rd_data,
  input wire logic scan_tick,
  // Watched outputs
  input wire logic drive_supply_enable,
  input wire logic [3:0] contrast_code,
  input wire logic [16:0] common_line,
  input wire logic [47:0] segment_line,
  input wire logic [1:0] duty_active,
  input wire logic exp_scan_pulse,
  input wire logic exp_frame_start,
  input wire logic [4:0] exp_common_index
);
  import ldc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire wr_cfg = bus_in.wr && bus_in.addr == LCD_DRIVE_CONFIG_ADDR;
  wire wr_con = bus_in.wr && bus_in.addr == LCD_CONTRAST_LEVEL_ADDR;
  wire on8 = drive_supply_enable && scan_tick && duty_active == 2'h2;
  property p_supply;
    wr_cfg |=> drive_supply_enable == $past(bus_in.wdata[0]);
  endproperty
  a_supply: assert property (p_supply) else $error("supply bit wrong");
  property p_dark;
    !drive_supply_enable && scan_tick |=> common_line == 17'h0 && segment_line == 48'h0;
  endproperty
  a_dark: assert property (p_dark) else $error("drive not off");
  property p_duty;
    wr_cfg |=> duty_active == ((LAYOUT_48X8 || $past(bus_in.wdata[3])) ? 2'h2
      : {1'b0, $past(bus_in.wdata[2])});
  endproperty
  a_duty: assert property (p_duty) else $error("duty wrong");
  property p_range8;
    on8 |=> common_line[16:8] == 9'h0;
  endproperty
  a_range8: assert property (p_range8) else $error("common beyond 7");
  property p_wrap8;
    on8 && common_line[7] |=> common_line == 17'h1;
  endproperty
  a_wrap8: assert property (p_wrap8) else $error("no wrap at 7");
  property p_contrast;
    wr_con |=> contrast_code == $past(bus_in.wdata);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast wrong");
  property p_exp;
    exp_scan_pulse |-> $past(scan_tick);
  endproperty
  a_exp: assert property (p_exp) else $error("stray scan pulse");
  property p_frame;
    exp_frame_start |-> exp_scan_pulse;
  endproperty
  a_frame: assert property (p_frame) else $error("stray frame start");
  property p_hole;
    bus_in.rd && bus_in.addr[15:8] == 8'hF0 && bus_in.addr[7:0] > 8'h5F |=> rd_data == 4'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("hole read not zero");
endmodule
bind ldc_lcd_drive_control ldc_properties #(.LAYOUT_48X8(LAYOUT_48X8)) u_props (
  .clock(clock), .rst_n(rst_n), .bus_in(bus_in), .rd_data(rd_data), .scan_tick(scan_tick),
  .drive_supply_enable(drive_supply_enable), .contrast_code(contrast_code),
  .common_line(common_line), .segment_line(segment_line), .duty_active(duty_active),
  .exp_scan_pulse(exp_scan_pulse), .exp_frame_start(exp_frame_start),
  .exp_common_index(exp_common_index));

/* File: testbench/ldc_panel_model.sv */
// Purpose: Panel side model that paces the scan and shows lit dots
// Assumes: One common active at a time
// Notes: Dots read zero while no common is driven
`timescale 1ns/1ps
module ldc_panel_model (
  // Step request from the bench
  input wire logic step_req,
  output logic scan_tick,
  // Panel pins
  input wire logic [16:0] common_line,
  input wire logic [47:0] segment_line,
  output logic [47:0] lit_dots
);
  assign scan_tick = step_req;
  assign lit_dots = (common_line != 17'h0) ? segment_line : 48'h0;
endmodule

/* File: testbench/tb_lcd_drive_control.sv */
// Purpose: Self-checking bench of the LCD drive control block
// Assumes: 40x17 layout, scan paced by the panel model
// Notes: Seg 0 column holds a known pattern across all commons
`timescale 1ns/1ps
module tb_lcd_drive_control;
  import ldc_pkg::*;
  localparam logic [16:0] SEG0 = 17'h1C2A5;
  logic clock, rst_n, step_req, scan_tick, drive_supply_enable, exp_scan_pulse;
  ldc_bus_type bus;
  logic [3:0] rd_data, contrast_code;
  logic [16:0] common_line;
  logic [47:0] segment_line, lit_dots;
  logic [1:0] duty_active;
  int fail_count, check_count;
  ldc_lcd_drive_control u_dut (.clock(clock), .rst_n(rst_n), .bus_in(bus), .rd_data(rd_data),
    .scan_tick(scan_tick), .drive_supply_enable(drive_supply_enable),
    .contrast_code(contrast_code), .common_line(common_line), .segment_line(segment_line),
    .duty_active(duty_active), .exp_scan_pulse(exp_scan_pulse), .exp_frame_start(),
    .exp_common_index());
  ldc_panel_model u_panel (.step_req(step_req), .scan_tick(scan_tick),
    .common_line(common_line), .segment_line(segment_line), .lit_dots(lit_dots));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clock);
    #1 bus = '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    #1 bus.wr = 1'b0;
  endtask
  task rchk(input logic [15:0] a, input logic [3:0] e);
    @(posedge clock);
    #1 bus = '{a, 4'h0, 1'b0, 1'b1};
    @(posedge clock);
    #1 bus.rd = 1'b0;
    chk(rd_data, e);
  endtask
  task tick;
    @(posedge clock);
    #1 step_req = 1'b1;
    @(posedge clock);
    #1 step_req = 1'b0;
  endtask
  task to_com0;
    tick();
    for (int i = 0; i < 20 && common_line !== 17'h1; i++) tick();
  endtask
  task t_reset;
    rchk(LCD_DRIVE_CONFIG_ADDR, 4'h0);
    rchk(LCD_DISPLAY_OVERRIDE_ADDR, 4'h4);
    chk(common_line, 17'h0);
    $display("reset test done");
  endtask
  task t_regs;
    wr(LCD_CONTRAST_LEVEL_ADDR, 4'hF);
    chk(contrast_code, 4'hF);
    rchk(LCD_CONTRAST_LEVEL_ADDR, 4'hF);
    wr(LCD_DISPLAY_OVERRIDE_ADDR, 4'h1);
    rchk(LCD_DISPLAY_OVERRIDE_ADDR, 4'h1);
    wr(16'hF060, 4'hF);
    rchk(16'hF060, 4'h0);
    wr(16'hF000, 4'h5);
    wr(16'hF001, 4'hA);
    wr(16'hF100, 4'h2);
    wr(16'hF101, 4'hC);
    wr(16'hF200, 4'h1);
    rchk(16'hF101, 4'hC);
    $display("register test done");
  endtask
  task t_duty;
    logic [1:0] c;
    int last;
    for (int m = 0; m < 4; m++) begin
      c = m[1:0];
      last = c[1] ? 7 : (c[0] ? 15 : 16);
      wr(LCD_DRIVE_CONFIG_ADDR, {c, 2'h1});
      chk(duty_active, c[1] ? 2'h2 : {1'b0, c[0]});
      to_com0();
      for (int k = 0; k <= last + 1; k++) begin
        chk(common_line, 17'h1 << (k % (last + 1)));
        chk(lit_dots[0], c[1] ? SEG0[8 + k % 8] : SEG0[k % (last + 1)]);
        tick();
      end
    end
    $display("duty test done");
  endtask
  task t_override;
    logic [3:0] v [4] = '{4'h2, 4'h4, 4'h6, 4'h0};
    logic [47:0] e [4] = '{48'h00FF_FFFF_FFFF, 48'h0, 48'h00FF_FFFF_FFFF, 48'h1};
    for (int i = 0; i < 4; i++) begin
      wr(LCD_DISPLAY_OVERRIDE_ADDR, v[i]);
      to_com0();
      chk(segment_line, e[i]);
    end
    $display("override test done");
  endtask
  task t_exp;
    wr(LCD_DISPLAY_OVERRIDE_ADDR, 4'h8);
    tick();
    chk(exp_scan_pulse, 1'b1);
    wr(LCD_DISPLAY_OVERRIDE_ADDR, 4'h0);
    tick();
    chk(exp_scan_pulse, 1'b0);
    $display("expanded test done");
  endtask
  task t_supply;
    wr(LCD_DRIVE_CONFIG_ADDR, 4'h0);
    chk(drive_supply_enable, 1'b0);
    tick();
    chk(common_line, 17'h0);
    chk(segment_line, 48'h0);
    $display("supply test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    bus = '0;
    step_req = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    t_reset();
    t_regs();
    t_duty();
    t_override();
    t_exp();
    t_supply();
    end_of_test();
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
